/* verilog/psr_readout.sv */
// Readout, status and calibration registers with a link-clock register port.
`timescale 1ns/1ps
`include "psr_consts.svh"

module psr_readout
  import psr_pkg::*;
#(
  parameter int DEPTH           = 128,
  parameter int BAT_1MS_CYCLES  = `PSR_BAT_SEL2_NS * `PSR_CLK_MHZ / 1000,
  parameter int BAT_25MS_CYCLES = `PSR_BAT_SEL3_NS * `PSR_CLK_MHZ / 1000
)
(
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        link_clk_i,
  input  wire logic [7:0]  bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_write_i,
  input  wire logic        bus_read_i,
  output logic      [7:0]  bus_rdata_o,
  output logic             bus_done_o,
  output logic             bus_busy_o,
  input  wire logic        pressure_valid_i,
  input  wire logic [23:0] pressure_raw_i,
  input  wire logic        temperature_valid_i,
  input  wire logic [15:0] temperature_raw_i,
  input  wire logic        fifo_enable_i,
  input  wire logic        auto_function_enable_i,
  input  wire logic        full_scale_select_i,
  input  wire logic        block_data_update_i,
  input  wire logic        boot_running_i,
  input  wire logic        low_pressure_event_i,
  input  wire logic        high_pressure_event_i,
  output logic [6:0]       fifo_threshold_level_o,
  output logic [15:0]      reference_pressure_value_o,
  output logic             spike_filter_always_on_o,
  output logic [20:0]      bus_available_cycles_o,
  output logic             full_scale_select_o
);

  // ==========================================================================
  // Link domain: register port and request handshake.
  // ==========================================================================
  logic               link_rst_meta;
  logic               link_nrst;
  psr_link_state_type link_state;
  logic               req_toggle;
  logic [7:0]         req_addr;
  logic [7:0]         req_wdata;
  logic               req_write;
  logic               ack_meta;
  logic               ack_sync;
  logic               ack_seen;
  logic               ack_toggle;
  logic [7:0]         core_rdata;

  always_ff @(posedge link_clk_i)
  begin
    link_rst_meta <= nrst_i;
    link_nrst     <= link_rst_meta;
  end

  always_ff @(posedge link_clk_i)
  begin
    ack_meta <= ack_toggle;
    ack_sync <= ack_meta;
  end

  always_ff @(posedge link_clk_i)
  begin
    if (!link_nrst)
    begin
      link_state  <= PSR_LINK_IDLE;
      req_toggle  <= 1'b0;
      ack_seen    <= 1'b0;
      req_addr    <= `PSR_BYTE_ZERO;
      req_wdata   <= `PSR_BYTE_ZERO;
      req_write   <= 1'b0;
      bus_rdata_o <= `PSR_BYTE_ZERO;
      bus_done_o  <= 1'b0;
    end
    else
    begin
      bus_done_o <= 1'b0;
      case (link_state)
        PSR_LINK_IDLE:
        begin
          if (bus_write_i || bus_read_i)
          begin
            req_addr   <= bus_addr_i;
            req_wdata  <= bus_wdata_i;
            req_write  <= bus_write_i;
            req_toggle <= ~req_toggle;
            link_state <= PSR_LINK_WAIT;
          end
        end
        PSR_LINK_WAIT:
        begin
          if (ack_sync != ack_seen)
          begin
            ack_seen    <= ack_sync;
            bus_rdata_o <= core_rdata;
            bus_done_o  <= 1'b1;
            link_state  <= PSR_LINK_IDLE;
          end
        end
        default:
          link_state <= PSR_LINK_IDLE;
      endcase
    end
  end

  assign bus_busy_o = (link_state == PSR_LINK_WAIT);

  // ==========================================================================
  // Core domain: request capture.
  // ==========================================================================
  logic       req_meta;
  logic       req_sync;
  logic       req_seen;
  logic       acc;
  logic       rd;
  logic       wr;

  always_ff @(posedge clock_i)
  begin
    req_meta <= req_toggle;
    req_sync <= req_meta;
  end

  assign acc = (req_sync != req_seen);
  assign rd  = acc && !req_write;
  assign wr  = acc && req_write;

  function automatic logic hit(input logic [7:0] a);
    hit = rd && (req_addr == a);
  endfunction

  // ==========================================================================
  // Writable configuration.
  // ==========================================================================
  logic [6:0]  thr;
  logic        spike_filter_always_on;
  logic [1:0]  bat_sel;
  logic [15:0] ofs;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      thr     <= 7'h00;
      spike_filter_always_on  <= 1'b0;
      bat_sel <= 2'h0;
      ofs     <= 16'h0000;
    end
    else if (wr)
    begin
      case (req_addr)
        `PSR_ADDR_FIFO_THR:  thr <= req_wdata[6:0];
        `PSR_ADDR_BUS_CTRL:
        begin
          spike_filter_always_on  <= req_wdata[`PSR_BUS_CTRL_ASF_BIT];
          bat_sel <= req_wdata[1:0];
        end
        `PSR_ADDR_OFS_LOW:   ofs[7:0]  <= req_wdata;
        `PSR_ADDR_OFS_HIGH:  ofs[15:8] <= req_wdata;
        default:             thr <= thr;
      endcase
    end
  end

  assign fifo_threshold_level_o   = thr;
  assign spike_filter_always_on_o = spike_filter_always_on;
  assign full_scale_select_o      = full_scale_select_i;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      bus_available_cycles_o <= 21'(`PSR_BAT_SEL0_NS * `PSR_CLK_MHZ / 1000);
    else
    begin
      case (psr_bat_type'(bat_sel))
        PSR_BAT_50US: bus_available_cycles_o <= 21'(`PSR_BAT_SEL0_NS * `PSR_CLK_MHZ / 1000);
        PSR_BAT_2US:  bus_available_cycles_o <= 21'(`PSR_BAT_SEL1_NS * `PSR_CLK_MHZ / 1000);
        PSR_BAT_1MS:  bus_available_cycles_o <= 21'(BAT_1MS_CYCLES);
        default:      bus_available_cycles_o <= 21'(BAT_25MS_CYCLES);
      endcase
    end
  end

  // ==========================================================================
  // Output data registers, block data update and data status.
  // ==========================================================================
  logic [23:0] p_comp;
  logic [23:0] p_out;
  logic [15:0] t_out;
  logic        bdu_lock;
  logic        p_da;
  logic        p_or;
  logic        t_da;
  logic        t_or;
  logic        p_pend;
  logic        t_pend;
  logic [23:0] p_hold;
  logic [15:0] t_hold;

  assign p_comp = pressure_raw_i + {{8{ofs[15]}}, ofs};

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      bdu_lock <= 1'b0;
    else if (hit(`PSR_ADDR_P_HIGH))
      bdu_lock <= 1'b0;
    else if (block_data_update_i && (hit(`PSR_ADDR_P_LOW) || hit(`PSR_ADDR_P_MID) ||
             hit(`PSR_ADDR_T_LOW) || hit(`PSR_ADDR_T_HIGH)))
      bdu_lock <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      p_out  <= 24'h00_0000;
      p_hold <= 24'h00_0000;
      p_pend <= 1'b0;
    end
    else if (pressure_valid_i && (bdu_lock || (block_data_update_i && hit(`PSR_ADDR_P_LOW))))
    begin
      p_hold <= p_comp;
      p_pend <= 1'b1;
    end
    else if (pressure_valid_i)
    begin
      p_out  <= p_comp;
      p_pend <= 1'b0;
    end
    else if (p_pend && !bdu_lock)
    begin
      p_out  <= p_hold;
      p_pend <= 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      t_out  <= 16'h0000;
      t_hold <= 16'h0000;
      t_pend <= 1'b0;
    end
    else if (temperature_valid_i && bdu_lock)
    begin
      t_hold <= temperature_raw_i;
      t_pend <= 1'b1;
    end
    else if (temperature_valid_i)
    begin
      t_out  <= temperature_raw_i;
      t_pend <= 1'b0;
    end
    else if (t_pend && !bdu_lock)
    begin
      t_out  <= t_hold;
      t_pend <= 1'b0;
    end
  end

  // Flags refresh on each result, once per output data rate cycle; set wins over read.
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      p_da <= 1'b0;
      p_or <= 1'b0;
      t_da <= 1'b0;
      t_or <= 1'b0;
    end
    else
    begin
      if (pressure_valid_i)
      begin
        p_da <= 1'b1;
        p_or <= p_da;
      end
      else if (hit(`PSR_ADDR_P_HIGH))
      begin
        p_da <= 1'b0;
        p_or <= 1'b0;
      end
      if (temperature_valid_i)
      begin
        t_da <= 1'b1;
        t_or <= t_da;
      end
      else if (hit(`PSR_ADDR_T_HIGH))
      begin
        t_da <= 1'b0;
        t_or <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Reference pressure.
  // ==========================================================================
  logic        auto_prev;
  logic [15:0] ref_p;

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      auto_prev <= 1'b0;
      ref_p     <= 16'h0000;
    end
    else
    begin
      auto_prev <= auto_function_enable_i;
      if (auto_function_enable_i && !auto_prev)
        ref_p <= p_out[23:8];
      else if (!auto_function_enable_i)
        ref_p <= 16'h0000;
    end
  end

  assign reference_pressure_value_o = ref_p;

  // ==========================================================================
  // Interrupt source, cleared by read.
  // ==========================================================================
  logic ia;
  logic pl;
  logic ph;
  logic src_rd;

  assign src_rd = hit(`PSR_ADDR_INT_SRC);

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      ia <= 1'b0;
      pl <= 1'b0;
      ph <= 1'b0;
    end
    else
    begin
      ia <= (low_pressure_event_i || high_pressure_event_i) || (ia && !src_rd);
      pl <= low_pressure_event_i || (pl && !src_rd);
      ph <= high_pressure_event_i || (ph && !src_rd);
    end
  end

  // ==========================================================================
  // Pressure FIFO.
  // ==========================================================================
  localparam int AW = $clog2(DEPTH);
  logic [23:0]   fifo_mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  logic          ovr;
  logic          push;
  logic          pop;
  logic          full;

  assign full = (count == (AW+1)'(DEPTH));
  assign push = fifo_enable_i && pressure_valid_i;
  assign pop  = hit(`PSR_ADDR_FP_HIGH) && (count != '0);

  always_ff @(posedge clock_i)
  begin
    if (push)
      fifo_mem[wr_ptr] <= p_comp;
  end

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      ovr    <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (push && full)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        ovr    <= 1'b1;
      end
      else if (push && pop)
        rd_ptr <= rd_ptr + 1'b1;
      else if (push)
        count <= count + 1'b1;
      else if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
        count  <= count - 1'b1;
        ovr    <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Read data.
  // ==========================================================================
  logic [23:0] fifo_head;

  assign fifo_head = fifo_mem[rd_ptr];

  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      req_seen   <= 1'b0;
      ack_toggle <= 1'b0;
      core_rdata <= `PSR_BYTE_ZERO;
    end
    else if (acc)
    begin
      req_seen   <= req_sync;
      ack_toggle <= ~ack_toggle;
      core_rdata <= `PSR_BYTE_ZERO;
      if (!req_write)
      begin
        case (req_addr)
          `PSR_ADDR_FIFO_THR:    core_rdata <= {1'b0, thr};
          `PSR_ADDR_REF_LOW:     core_rdata <= ref_p[7:0];
          `PSR_ADDR_REF_HIGH:    core_rdata <= ref_p[15:8];
          `PSR_ADDR_BUS_CTRL:    core_rdata <= `PSR_BUS_CTRL_FIXED | {2'b00, spike_filter_always_on, 3'b000, bat_sel};
          `PSR_ADDR_OFS_LOW:     core_rdata <= ofs[7:0];
          `PSR_ADDR_OFS_HIGH:    core_rdata <= ofs[15:8];
          `PSR_ADDR_INT_SRC:
          begin
            core_rdata[`PSR_BIT_BOOT] <= boot_running_i;
            core_rdata[`PSR_BIT_IA]   <= ia;
            core_rdata[`PSR_BIT_PL]   <= pl;
            core_rdata[`PSR_BIT_PH]   <= ph;
          end
          `PSR_ADDR_FIFO_LEVEL:  core_rdata <= 8'(count);
          `PSR_ADDR_FIFO_FLAGS:
          begin
            core_rdata[`PSR_BIT_FIFO_THRESHOLD]  <= (count >= {1'b0, thr});
            core_rdata[`PSR_BIT_FIFO_OVR]  <= full && ovr;
            core_rdata[`PSR_BIT_FIFO_FULL] <= full && !ovr;
          end
          `PSR_ADDR_DATA_STATUS:
          begin
            core_rdata[`PSR_BIT_T_OR] <= t_or;
            core_rdata[`PSR_BIT_P_OR] <= p_or;
            core_rdata[`PSR_BIT_T_DA] <= t_da;
            core_rdata[`PSR_BIT_P_DA] <= p_da;
          end
          `PSR_ADDR_P_LOW:       core_rdata <= p_out[7:0];
          `PSR_ADDR_P_MID:       core_rdata <= p_out[15:8];
          `PSR_ADDR_P_HIGH:      core_rdata <= p_out[23:16];
          `PSR_ADDR_T_LOW:       core_rdata <= t_out[7:0];
          `PSR_ADDR_T_HIGH:      core_rdata <= t_out[15:8];
          `PSR_ADDR_FP_LOW:      core_rdata <= fifo_head[7:0];
          `PSR_ADDR_FP_MID:      core_rdata <= fifo_head[15:8];
          `PSR_ADDR_FP_HIGH:     core_rdata <= fifo_head[23:16];
          default:               core_rdata <= `PSR_BYTE_ZERO;
        endcase
      end
    end
  end

endmodule

/* verilog/psr_consts.svh */
// Register map, field positions, reset values and timing constants of the readout block.
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

`define PSR_ADDR_FIFO_THR      8'h15
`define PSR_ADDR_REF_LOW       8'h16
`define PSR_ADDR_REF_HIGH      8'h17
`define PSR_ADDR_BUS_CTRL      8'h19
`define PSR_ADDR_OFS_LOW       8'h1A
`define PSR_ADDR_OFS_HIGH      8'h1B
`define PSR_ADDR_INT_SRC       8'h24
`define PSR_ADDR_FIFO_LEVEL    8'h25
`define PSR_ADDR_FIFO_FLAGS    8'h26
`define PSR_ADDR_DATA_STATUS   8'h27
`define PSR_ADDR_P_LOW         8'h28
`define PSR_ADDR_P_MID         8'h29
`define PSR_ADDR_P_HIGH        8'h2A
`define PSR_ADDR_T_LOW         8'h2B
`define PSR_ADDR_T_HIGH        8'h2C
`define PSR_ADDR_FP_LOW        8'h78
`define PSR_ADDR_FP_MID        8'h79
`define PSR_ADDR_FP_HIGH       8'h7A

`define PSR_BYTE_ZERO          8'h00
`define PSR_BUS_CTRL_FIXED     8'h80
`define PSR_BUS_CTRL_ASF_BIT   5
`define PSR_BIT_BOOT           7
`define PSR_BIT_IA             2
`define PSR_BIT_PL             1
`define PSR_BIT_PH             0
`define PSR_BIT_FIFO_THRESHOLD       7
`define PSR_BIT_FIFO_OVR       6
`define PSR_BIT_FIFO_FULL      5
`define PSR_BIT_T_OR           5
`define PSR_BIT_P_OR           4
`define PSR_BIT_T_DA           1
`define PSR_BIT_P_DA           0

`define PSR_CLK_MHZ            50
`define PSR_BAT_SEL0_NS        50000
`define PSR_BAT_SEL1_NS        2000
`define PSR_BAT_SEL2_NS        1000000
`define PSR_BAT_SEL3_NS        25000000

`endif

/* verilog/psr_pkg.sv */
// Types shared by the readout block.
package psr_pkg;
  typedef enum logic [1:0] {
    PSR_BAT_50US,
    PSR_BAT_2US,
    PSR_BAT_1MS,
    PSR_BAT_25MS
  } psr_bat_type;

  typedef enum {
    PSR_LINK_IDLE,
    PSR_LINK_WAIT
  } psr_link_state_type;
endpackage

/* test/psr_readout_monitor.sv */
// Concurrent checks on the register port and level outputs of the readout block.
`timescale 1ns/1ps

module psr_readout_monitor
#(
  parameter int BAT_1MS_CYCLES  = 50000,
  parameter int BAT_25MS_CYCLES = 1250000
)
(
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        link_clk_i,
  input wire logic        bus_write_i,
  input wire logic        bus_read_i,
  input wire logic [7:0]  bus_rdata_o,
  input wire logic        bus_done_o,
  input wire logic        bus_busy_o,
  input wire logic        auto_function_enable_i,
  input wire logic        full_scale_select_i,
  input wire logic [15:0] reference_pressure_value_o,
  input wire logic [20:0] bus_available_cycles_o,
  input wire logic        full_scale_select_o
);
  // Link-side checks start only once the design's synchronised link reset has settled.
  logic [3:0] link_rst_pipe = 4'h0;
  logic       link_ok;

  always_ff @(posedge link_clk_i)
  begin
    link_rst_pipe <= {link_rst_pipe[2:0], nrst_i};
  end

  assign link_ok = &link_rst_pipe;

  // ====================================================================
  // Register port handshake.
  chk_done_one_cycle: assert property (@(posedge link_clk_i) disable iff (!link_ok)
    bus_done_o |=> !bus_done_o) else $error("done pulse too long");
  chk_req_taken: assert property (@(posedge link_clk_i) disable iff (!link_ok)
    (bus_read_i || bus_write_i) && !bus_busy_o |=> bus_busy_o) else $error("request lost");
  chk_done_in_time: assert property (@(posedge link_clk_i) disable iff (!link_ok)
    $rose(bus_busy_o) |-> ##[1:16] bus_done_o) else $error("access never ends");
  chk_done_after_busy: assert property (@(posedge link_clk_i) disable iff (!link_ok)
    bus_done_o |-> $past(bus_busy_o)) else $error("done without access");
  chk_rdata_held: assert property (@(posedge link_clk_i) disable iff (!link_ok)
    !bus_done_o |-> $stable(bus_rdata_o)) else $error("read data moved between accesses");
  // ====================================================================
  // Level outputs in the core domain.
  chk_scale_follow: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $stable(full_scale_select_i) |-> full_scale_select_o == full_scale_select_i)
    else $error("scale select not passed on");
  chk_bat_legal: assert property (@(posedge clock_i) disable iff (!nrst_i)
    bus_available_cycles_o inside {21'h00_09c4, 21'h00_0064, 21'(BAT_1MS_CYCLES),
    21'(BAT_25MS_CYCLES)}) else $error("bus available time not a listed value");
  chk_ref_off_zero: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !auto_function_enable_i [*3] |-> reference_pressure_value_o == 16'h0000)
    else $error("reference shown while auto function off");
  cover property (@(posedge link_clk_i) bus_done_o && bus_rdata_o != 8'h00);
  cover property (@(posedge clock_i) $rose(auto_function_enable_i));
  cover property (@(posedge clock_i) bus_available_cycles_o == 21'(BAT_25MS_CYCLES));
endmodule

/* test/psr_host_model.sv */
// Host model issuing byte register accesses on the link clock.
`timescale 1ns/1ps

module psr_host_model
(
  input  wire logic       link_clk_i,
  input  wire logic [7:0] bus_rdata_i,
  input  wire logic       bus_done_i,
  output logic      [7:0] bus_addr_o,
  output logic      [7:0] bus_wdata_o,
  output logic            bus_write_o,
  output logic            bus_read_o
);
  initial
  begin
    bus_addr_o  = 8'h00;
    bus_wdata_o = 8'h00;
    bus_write_o = 1'b0;
    bus_read_o  = 1'b0;
  end

  // The request is a one-cycle pulse; address and data stay until done is seen or the 40-cycle wait runs out, then
  // they are inverted so a stale value is never mistaken for a live one.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data,
                        output logic [7:0] rdata);
    int n;
    n     = 0;
    rdata = 8'hxx;
    @(posedge link_clk_i);
    bus_addr_o  <= addr;
    bus_wdata_o <= data;
    bus_write_o <= wr;
    bus_read_o  <= !wr;
    @(posedge link_clk_i);
    bus_write_o <= 1'b0;
    bus_read_o  <= 1'b0;
    while (bus_done_i !== 1'b1 && n < 40)
    begin
      @(posedge link_clk_i);
      n++;
    end
    if (bus_done_i === 1'b1)
      rdata = bus_rdata_i;
    bus_addr_o  <= ~addr;
    bus_wdata_o <= ~data;
  endtask
endmodule

/* test/psr_readout_test.sv */
// Self-checking bench of the readout block, driven through the host model.
`timescale 1ns/1ps

module psr_readout_test import psr_pkg::*;;
  localparam int B1  = 50;
  localparam int B25 = 100;

  logic        clock_i                = 1'b0;
  logic        link_clk_i             = 1'b0;
  logic        nrst_i                 = 1'b0;
  logic [7:0]  bus_addr_i;
  logic [7:0]  bus_wdata_i;
  logic        bus_write_i;
  logic        bus_read_i;
  logic [7:0]  bus_rdata_o;
  logic        bus_done_o;
  logic        bus_busy_o;
  logic        pressure_valid_i       = 1'b0;
  logic [23:0] pressure_raw_i         = 24'h00_0000;
  logic        temperature_valid_i    = 1'b0;
  logic [15:0] temperature_raw_i      = 16'h0000;
  logic        fifo_enable_i          = 1'b0;
  logic        auto_function_enable_i = 1'b0;
  logic        full_scale_select_i    = 1'b0;
  logic        block_data_update_i    = 1'b0;
  logic        boot_running_i         = 1'b0;
  logic        low_pressure_event_i   = 1'b0;
  logic        high_pressure_event_i  = 1'b0;
  logic [6:0]  fifo_threshold_level_o;
  logic [15:0] reference_pressure_value_o;
  logic        spike_filter_always_on_o;
  logic [20:0] bus_available_cycles_o;
  logic        full_scale_select_o;
  int          n_errors               = 0;
  int          compares               = 0;

  always #10 clock_i = ~clock_i;
  initial
  begin
    #37;
    forever #62.5 link_clk_i = ~link_clk_i;
  end

  psr_readout #(.BAT_1MS_CYCLES(B1), .BAT_25MS_CYCLES(B25)) dut (.clock_i, .nrst_i,
    .link_clk_i, .bus_addr_i, .bus_wdata_i, .bus_write_i, .bus_read_i, .bus_rdata_o,
    .bus_done_o, .bus_busy_o, .pressure_valid_i, .pressure_raw_i, .temperature_valid_i,
    .temperature_raw_i, .fifo_enable_i, .auto_function_enable_i, .full_scale_select_i,
    .block_data_update_i, .boot_running_i, .low_pressure_event_i, .high_pressure_event_i,
    .fifo_threshold_level_o, .reference_pressure_value_o, .spike_filter_always_on_o,
    .bus_available_cycles_o, .full_scale_select_o);

  psr_host_model host (.link_clk_i, .bus_rdata_i(bus_rdata_o), .bus_done_i(bus_done_o),
    .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i), .bus_write_o(bus_write_i),
    .bus_read_o(bus_read_i));

  // ====================================================================
  // Compare, access and stimulus helpers.
  task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD reg %h expected %h seen %h", a, e, g);
    end
  endtask

  task automatic chkw(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.access(1'b0, a, 8'h00, q);
    chk(a, e, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.access(1'b1, a, d, q);
  endtask

  task automatic ppush(input logic [23:0] v);
    @(posedge clock_i);
    pressure_raw_i   <= v;
    pressure_valid_i <= 1'b1;
    @(posedge clock_i);
    pressure_valid_i <= 1'b0;
  endtask

  task automatic tpush(input logic [15:0] v);
    @(posedge clock_i);
    temperature_raw_i   <= v;
    temperature_valid_i <= 1'b1;
    @(posedge clock_i);
    temperature_valid_i <= 1'b0;
  endtask

  task automatic evt(input logic lo);
    @(posedge clock_i);
    low_pressure_event_i  <= lo;
    high_pressure_event_i <= !lo;
    @(posedge clock_i);
    low_pressure_event_i  <= 1'b0;
    high_pressure_event_i <= 1'b0;
  endtask

  // ====================================================================
  // Scenarios.
  task automatic t_reset;
    logic [15:0] t [11] = '{16'h1500, 16'h1600, 16'h1700, 16'h1980, 16'h1a00, 16'h1b00,
                            16'h2400, 16'h2500, 16'h2680, 16'h2700, 16'h5000};
    foreach (t[i]) rd(t[i][15:8], t[i][7:0]);
    chkw("bat", 24'h00_09c4, 24'(bus_available_cycles_o));
  endtask

  task automatic t_config;
    logic [23:0] bat [4] = '{24'h00_09c4, 24'h00_0064, 24'(B1), 24'(B25)};
    wr(8'h15, 8'h05);
    rd(8'h15, 8'h05);
    chkw("thr", 24'h00_0005, 24'(fifo_threshold_level_o));
    wr(8'h16, 8'h5a);
    rd(8'h16, 8'h00);
    @(posedge clock_i);
    full_scale_select_i <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      wr(8'h19, 8'h20 | 8'(s));
      rd(8'h19, 8'ha0 | 8'(s));
      chkw("filter", 24'h00_0001, 24'(spike_filter_always_on_o));
      chkw("bat", bat[s], 24'(bus_available_cycles_o));
    end
    chkw("scale", 24'h00_0001, 24'(full_scale_select_o));
    wr(8'h19, 8'h00);
    chkw("filter", 24'h00_0000, 24'(spike_filter_always_on_o));
    @(posedge clock_i);
    full_scale_select_i <= 1'b0;
  endtask

  task automatic t_pressure;
    wr(8'h1a, 8'hfe);
    wr(8'h1b, 8'hff);
    rd(8'h1a, 8'hfe);
    rd(8'h1b, 8'hff);
    ppush(24'h12_3456);
    rd(8'h27, 8'h01);
    rd(8'h28, 8'h54);
    rd(8'h29, 8'h34);
    rd(8'h2a, 8'h12);
    rd(8'h27, 8'h00);
    ppush(24'h00_0001);
    ppush(24'h00_0000);
    tpush(16'h1234);
    tpush(16'habcd);
    rd(8'h27, 8'h33);
    rd(8'h28, 8'hfe);
    rd(8'h29, 8'hff);
    rd(8'h2a, 8'hff);
    rd(8'h2b, 8'hcd);
    rd(8'h2c, 8'hab);
    rd(8'h27, 8'h00);
  endtask

  task automatic t_hold;
    @(posedge clock_i);
    block_data_update_i <= 1'b1;
    ppush(24'h65_4321);
    rd(8'h28, 8'h1f);
    ppush(24'h11_1111);
    rd(8'h29, 8'h43);
    rd(8'h2a, 8'h65);
    ppush(24'h11_1111);
    rd(8'h28, 8'h0f);
    rd(8'h2a, 8'h11);
    @(posedge clock_i);
    block_data_update_i <= 1'b0;
  endtask

  task automatic t_reference;
    rd(8'h17, 8'h00);
    @(posedge clock_i);
    auto_function_enable_i <= 1'b1;
    rd(8'h16, 8'h11);
    rd(8'h17, 8'h11);
    chkw("ref", 24'h00_1111, 24'(reference_pressure_value_o));
    @(posedge clock_i);
    auto_function_enable_i <= 1'b0;
    rd(8'h16, 8'h00);
  endtask

  task automatic t_events;
    @(posedge clock_i);
    boot_running_i <= 1'b1;
    evt(1'b1);
    rd(8'h24, 8'h86);
    rd(8'h24, 8'h80);
    @(posedge clock_i);
    boot_running_i <= 1'b0;
    evt(1'b0);
    rd(8'h24, 8'h05);
    rd(8'h24, 8'h00);
  endtask

  task automatic t_fifo;
    wr(8'h15, 8'h02);
    @(posedge clock_i);
    fifo_enable_i <= 1'b1;
    ppush(24'h00_0100);
    ppush(24'h00_0200);
    rd(8'h25, 8'h02);
    rd(8'h26, 8'h80);
    rd(8'h78, 8'hfe);
    rd(8'h79, 8'h00);
    rd(8'h7a, 8'h00);
    rd(8'h25, 8'h01);
    rd(8'h26, 8'h00);
    repeat (127) ppush(24'h00_0300);
    rd(8'h25, 8'h80);
    rd(8'h26, 8'ha0);
    ppush(24'h00_0400);
    rd(8'h26, 8'hc0);
    rd(8'h79, 8'h02);
    rd(8'h7a, 8'h00);
    rd(8'h25, 8'h7f);
    rd(8'h26, 8'h80);
  endtask

  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    n_errors++;
    end_of_test;
  end

  initial
  begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge link_clk_i);
    t_reset;
    t_config;
    t_pressure;
    t_hold;
    t_reference;
    t_events;
    t_fifo;
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (30) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge link_clk_i);
    rd(8'h15, 8'h00);
    rd(8'h25, 8'h00);
    end_of_test;
  end
endmodule

bind psr_readout psr_readout_monitor #(.BAT_1MS_CYCLES(BAT_1MS_CYCLES),
  .BAT_25MS_CYCLES(BAT_25MS_CYCLES)) mon (.clock_i, .nrst_i, .link_clk_i, .bus_write_i,
  .bus_read_i, .bus_rdata_o, .bus_done_o, .bus_busy_o, .auto_function_enable_i,
  .full_scale_select_i, .reference_pressure_value_o, .bus_available_cycles_o,
  .full_scale_select_o);
